// File: cvrt_pkg.sv
// Package of constants and types for the vector and ROM table logic
package cvrt_pkg;
  localparam int          CVRT_PC_W        = 11;         // Program address width
  localparam logic [10:0] CVRT_RESET_VEC   = 11'h000;    // Reset vector word
  localparam logic [10:0] CVRT_IRQ_VEC     = 11'h008;    // Interrupt vector word
  localparam int          CVRT_STACK_DEPTH = 8;          // Return stack levels
  localparam int          CVRT_SP_W        = 3;          // Stack pointer width
  localparam logic [2:0]  CVRT_SP_MAX      = 3'h7;       // Deepest stack slot
  localparam logic [7:0]  CVRT_BYTE_ZERO   = 8'h00;      // Reset byte value
  localparam int          CVRT_TO_BIT      = 4;          // Time-out flag bit
  localparam int          CVRT_PD_BIT      = 5;          // Power-down flag bit
  localparam logic [7:0]  CVRT_KEEP_MASK   = 8'h30;      // Bits kept on restore
  localparam logic [3:0]  CVRT_PCH_W_MASK  = 4'h7;       // High byte fetch bits

  // Reset causes
  typedef enum logic [1:0] {
    CVRT_RST_POWER,
    CVRT_RST_WDOG,
    CVRT_RST_EXT
  } cvrt_rst_type;

  // Operations presented by the decoder
  typedef enum logic [2:0] {
    CVRT_OP_STEP,
    CVRT_OP_IRQ,
    CVRT_OP_RETURN_FROM_INTERRUPT,
    CVRT_OP_SAVE,
    CVRT_OP_RESTORE,
    CVRT_OP_TABLE,
    CVRT_OP_PCL_ADD,
    CVRT_OP_PCL_SUB
  } cvrt_op_type;

  // Fetch sequencer states
  typedef enum logic [1:0] {
    CVRT_ST_RESET,
    CVRT_ST_RUN,
    CVRT_ST_TABLE
  } cvrt_state_type;

  // Word address from a high and a low byte, cut to fetch width
  function automatic logic [10:0] cvrt_word_addr(input logic [7:0] hi,
                                                 input logic [7:0] lo);
    logic [15:0] full;
    full = {hi, lo};
    return full[10:0];
  endfunction
endpackage : cvrt_pkg

// File: cvrt_stack_if.sv
// Interface between the sequencer and its return-address stack
`timescale 1ns/100ps
`default_nettype none
interface cvrt_stack_if;
  import cvrt_pkg::*;
  logic        push;   // Store a return address
  logic        pop;    // Take the latest address back
  logic [10:0] wdata;  // Address to store
  logic [10:0] rdata;  // Latest stored address
  modport seq (output push, output pop, output wdata, input rdata);
  modport stk (input push, input pop, input wdata, output rdata);
endinterface : cvrt_stack_if
`default_nettype wire

// File: cvrt_stack.sv
// Eight-level circular return-address stack
`timescale 1ns/100ps
`default_nettype none
module cvrt_stack
  import cvrt_pkg::*;
(
  input  wire logic  clk_in,      // Instruction clock
  input  wire logic  reset_n_in,  // Async reset, active low
  cvrt_stack_if.stk  stk          // Push and pop port
);
  logic [10:0]  mem_ff [CVRT_STACK_DEPTH];  // Stored addresses
  logic [2:0]   sp_ff;                      // Next free slot
  logic [2:0]   top_idx;                    // Latest slot

  assign top_idx   = sp_ff - 3'h1;
  assign stk.rdata = mem_ff[top_idx];

  // Pointer wraps; an overflowing push drops the oldest entry silently
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sp_ff <= '0;
    end else if (stk.push) begin
      sp_ff <= sp_ff + 3'h1;
    end else if (stk.pop) begin
      sp_ff <= top_idx;
    end
  end

  // Storage is not reset, software never reads an empty slot
  always_ff @(posedge clk_in) begin
    if (stk.push) begin
      mem_ff[sp_ff] <= stk.wdata;
    end
  end
endmodule : cvrt_stack
`default_nettype wire

// File: cvrt_core.sv
// Program sequencer: vectors, return stack, shadow save, table reads
// Summary of operation
// - Any reset loads defaults, fetches from zero
// - Reset vector is the single word zero
// - Reset cause sets time-out and power-down flags
// - Interrupt pushes PC, fetches interrupt vector
// - Save copies value and flags, restore all but cause flags, PC steps one
// - Shadow buffer has exactly one level
// - Table address is middle index then low
// - Table low byte to value, high to data
// - Low index increment never carries upward
// - Value added to PC low picks jump entry
// - Carry from PC low add bumps high byte
// - Borrow from PC low subtract leaves high
// - Return stack holds eight levels
`timescale 1ns/100ps
`default_nettype none
module cvrt_core
  import cvrt_pkg::*;
(
  input  wire logic         clk_in,          // Instruction clock, 40 MHz
  input  wire logic         reset_n_in,      // Async reset, active low
  input  wire cvrt_rst_type rst_cause_in,    // Cause of the last reset
  input  wire logic         op_valid_in,     // Operation present this cycle
  input  wire cvrt_op_type  op_in,           // Operation code
  input  wire logic [7:0]   op_value_in,     // Operand for PC low arithmetic
  input  wire logic         idx_lo_inc_in,   // Increment low index
  input  wire logic         idx_lo_wr_in,    // Load low index
  input  wire logic         idx_mid_wr_in,   // Load middle index
  input  wire logic [7:0]   idx_data_in,     // Index load data
  input  wire logic         value_wr_in,     // Load working value
  input  wire logic         flags_wr_in,     // Load flag byte
  input  wire logic [7:0]   wdata_in,        // Value or flag load data
  input  wire logic [15:0]  rom_data_in,     // Word read from ROM
  output logic [10:0]       rom_addr_out,    // ROM word address
  output logic [7:0]        working_value_out,   // Accumulator
  output logic [7:0]        status_flag_byte_out, // Flag byte
  output logic [7:0]        table_high_out,  // High byte of table word
  output logic [7:0]        idx_lo_out,      // Low index register
  output logic [7:0]        idx_mid_out,     // Middle index register
  output logic              busy_out         // Table read in progress
);
  cvrt_state_type state_ff;        // Sequencer state
  logic [7:0]     pc_low_byte;     // Low byte of program counter
  logic [2:0]     pc_high_byte;    // High bits of program counter
  logic [7:0]     shadow_val_ff;   // One-level saved value
  logic [7:0]     shadow_flg_ff;   // One-level saved flags
  logic [10:0]    pc_ret_ff;       // Fetch address held during a table read
  logic [8:0]     pcl_sum;         // Low byte add with carry
  logic [8:0]     pcl_dif;         // Low byte subtract with borrow
  logic           is_op;           // Helper: operation of a kind
  cvrt_stack_if   stk_if ();       // Stack connection

  assign pc_low_byte  = rom_addr_out[7:0];
  assign pc_high_byte = rom_addr_out[10:8];
  assign pcl_sum = {1'b0, pc_low_byte} + {1'b0, op_value_in};
  assign pcl_dif = {1'b0, pc_low_byte} - {1'b0, op_value_in};
  assign is_op   = op_valid_in && (state_ff == CVRT_ST_RUN);

  // Stack driven by interrupt entry and return
  assign stk_if.push  = is_op && (op_in == CVRT_OP_IRQ);
  assign stk_if.pop   = is_op && (op_in == CVRT_OP_RETURN_FROM_INTERRUPT);
  assign stk_if.wdata = rom_addr_out;

  cvrt_stack u_stack (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .stk        (stk_if.stk)
  );

  // Sequencer: a table read takes one extra cycle on the ROM port
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff <= CVRT_ST_RESET;
    end else begin
      unique case (state_ff)
        CVRT_ST_RESET: begin
          state_ff <= CVRT_ST_RUN;
        end
        CVRT_ST_RUN: begin
          if (op_valid_in && op_in == CVRT_OP_TABLE) begin
            state_ff <= CVRT_ST_TABLE;
          end
        end
        CVRT_ST_TABLE: begin
          state_ff <= CVRT_ST_RUN;
        end
      endcase
    end
  end

  // Program counter and ROM address
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rom_addr_out <= CVRT_RESET_VEC;
      pc_ret_ff    <= CVRT_RESET_VEC;
    end else if (state_ff == CVRT_ST_TABLE) begin
      rom_addr_out <= pc_ret_ff + 11'h001;  // Resume after the read
    end else if (state_ff == CVRT_ST_RESET) begin
      rom_addr_out <= CVRT_RESET_VEC;
    end else if (op_valid_in) begin
      unique case (op_in)
        CVRT_OP_IRQ:     rom_addr_out <= CVRT_IRQ_VEC;
        CVRT_OP_RETURN_FROM_INTERRUPT:    rom_addr_out <= stk_if.rdata;
        CVRT_OP_TABLE: begin
          pc_ret_ff    <= rom_addr_out;
          rom_addr_out <= cvrt_word_addr(idx_mid_out, idx_lo_out);
        end
        CVRT_OP_PCL_ADD: begin
          // Carry bumps the high bits; wrap past the top is dropped
          rom_addr_out <= {pc_high_byte + {2'b00, pcl_sum[8]},
                           pcl_sum[7:0]};
        end
        CVRT_OP_PCL_SUB: begin
          rom_addr_out <= {pc_high_byte, pcl_dif[7:0]};
        end
        default:         rom_addr_out <= rom_addr_out + 11'h001;
      endcase
    end else begin
      rom_addr_out <= rom_addr_out + 11'h001;
    end
  end

  // Index registers; low increment has no carry path
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      idx_lo_out  <= CVRT_BYTE_ZERO;
      idx_mid_out <= CVRT_BYTE_ZERO;
    end else begin
      if (idx_lo_wr_in) begin
        idx_lo_out <= idx_data_in;
      end else if (idx_lo_inc_in) begin
        idx_lo_out <= idx_lo_out + 8'h01;
      end
      if (idx_mid_wr_in) begin
        idx_mid_out <= idx_data_in;
      end
    end
  end

  // Working value and table high byte
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      working_value_out <= CVRT_BYTE_ZERO;
      table_high_out    <= CVRT_BYTE_ZERO;
    end else if (state_ff == CVRT_ST_TABLE) begin
      working_value_out <= rom_data_in[7:0];
      table_high_out    <= rom_data_in[15:8];
    end else if (is_op && op_in == CVRT_OP_RESTORE) begin
      working_value_out <= shadow_val_ff;
    end else if (value_wr_in) begin
      working_value_out <= wdata_in;
    end
  end

  // Flag byte; cause flags are owned by reset, not by restore
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status_flag_byte_out <= CVRT_BYTE_ZERO;
    end else if (state_ff == CVRT_ST_RESET) begin
      // Cause captured after release, never under the async reset
      status_flag_byte_out[CVRT_TO_BIT] <=
        (rst_cause_in != CVRT_RST_WDOG);
      status_flag_byte_out[CVRT_PD_BIT] <=
        (rst_cause_in == CVRT_RST_EXT);
    end else if (is_op && op_in == CVRT_OP_RESTORE) begin
      status_flag_byte_out <= (shadow_flg_ff & ~CVRT_KEEP_MASK) |
                              (status_flag_byte_out & CVRT_KEEP_MASK);
    end else if (flags_wr_in) begin
      status_flag_byte_out <= (wdata_in & ~CVRT_KEEP_MASK) |
                              (status_flag_byte_out & CVRT_KEEP_MASK);
    end
  end

  // Single shadow slot; a second save overwrites the first
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shadow_val_ff <= CVRT_BYTE_ZERO;
      shadow_flg_ff <= CVRT_BYTE_ZERO;
    end else if (is_op && op_in == CVRT_OP_SAVE) begin
      shadow_val_ff <= working_value_out;
      shadow_flg_ff <= status_flag_byte_out;
    end
  end

  // Busy during the table data cycle
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy_out <= 1'b1;
    end else begin
      busy_out <= (state_ff == CVRT_ST_RUN) && op_valid_in &&
                  (op_in == CVRT_OP_TABLE);
    end
  end

  // Checks
  // Fetch restarts at the reset vector after release
  AST_RESET_VEC: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    state_ff == CVRT_ST_RESET |=> rom_addr_out == CVRT_RESET_VEC)
    else $error("fetch not at reset vector");
  // Taken interrupt always lands on its vector
  AST_IRQ_VEC: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    stk_if.push |=> rom_addr_out == CVRT_IRQ_VEC)
    else $error("interrupt vector missed");
  // Immediate return comes back where the interrupt left
  AST_RETURN_FROM_INTERRUPT: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    (stk_if.push ##1 stk_if.pop) |=> rom_addr_out == $past(rom_addr_out, 2))
    else $error("return address wrong");
  // Spare middle index bits never reach the ROM port
  AST_TABLE_ADDR: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    is_op && op_in == CVRT_OP_TABLE |=>
      rom_addr_out == {$past(idx_mid_out[2:0]), $past(idx_lo_out)})
    else $error("table address wrong");
  AST_TABLE_DATA: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    state_ff == CVRT_ST_TABLE |=>
      working_value_out == $past(rom_data_in[7:0]) &&
      table_high_out == $past(rom_data_in[15:8]))
    else $error("table data wrong");
  // Software owns the middle index, hardware never carries
  AST_NO_CARRY: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    idx_lo_inc_in && !idx_lo_wr_in && !idx_mid_wr_in |=>
      idx_mid_out == $past(idx_mid_out))
    else $error("low index carried");
  AST_PCL_CARRY: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    is_op && op_in == CVRT_OP_PCL_ADD && pcl_sum[8] |=>
      pc_high_byte == $past(pc_high_byte) + 3'h1)
    else $error("carry did not bump high");
  AST_PCL_BORROW: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    is_op && op_in == CVRT_OP_PCL_SUB |=>
      pc_high_byte == $past(pc_high_byte))
    else $error("borrow changed high");
  // Restore brings the value back but leaves the cause flags
  AST_SAVE_RESTORE: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    is_op && op_in == CVRT_OP_RESTORE |=>
      working_value_out == $past(shadow_val_ff) &&
      status_flag_byte_out[CVRT_PD_BIT:CVRT_TO_BIT] ==
        $past(status_flag_byte_out[CVRT_PD_BIT:CVRT_TO_BIT]))
    else $error("restore value wrong");
  AST_CAUSE: assert property (
    @(posedge clk_in) disable iff (!reset_n_in)
    state_ff == CVRT_ST_RESET && rst_cause_in == CVRT_RST_WDOG |=>
      !status_flag_byte_out[CVRT_TO_BIT] &&
      !status_flag_byte_out[CVRT_PD_BIT])
    else $error("reset cause flags wrong");
  COV_IRQ: cover property (@(posedge clk_in) stk_if.push ##[1:20] stk_if.pop);
  COV_TABLE: cover property (@(posedge clk_in) state_ff == CVRT_ST_TABLE);
  COV_CARRY: cover property (@(posedge clk_in)
    is_op && op_in == CVRT_OP_PCL_ADD && pcl_sum[8]);
endmodule : cvrt_core
`default_nettype wire

// File: cvrt_rom_model.sv
// Program ROM model answering word reads combinationally
`timescale 1ns/100ps
`default_nettype none
module cvrt_rom_model (
  input  wire logic [10:0] addr_in,  // Word address from the core
  output logic      [15:0] data_out  // Word stored at that address
);
  // Word pattern ties both bytes to the address, so a wrong
  // address or swapped bytes show up as a wrong value
  assign data_out = {5'h15, addr_in};
endmodule // cvrt_rom_model
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the vector and ROM table logic
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import cvrt_pkg::*;
  logic         clk_in = 1'b0;  // 40 MHz instruction clock
  logic         rst_n  = 1'b0;  // Async reset, active low
  cvrt_rst_type cause  = CVRT_RST_POWER;  // Reset cause shown
  logic         opv    = 1'b0;  // Operation valid
  cvrt_op_type  op     = CVRT_OP_STEP;    // Operation code
  logic [7:0]   opval  = 8'h00; // Operand
  logic         inc    = 1'b0;  // Low index increment
  logic         lowr   = 1'b0;  // Low index load
  logic         midwr  = 1'b0;  // Middle index load
  logic [7:0]   idat   = 8'h00; // Index data
  logic         vwr    = 1'b0;  // Working value load
  logic         fwr    = 1'b0;  // Flag byte load
  logic [7:0]   wdat   = 8'h00; // Value or flag data
  logic [15:0]  rdata;          // ROM word
  logic [10:0]  addr;           // Fetch address
  logic [7:0]   val, flg, hi, lo, mid; // Byte outputs
  logic         busy;           // Table cycle flag
  int           fail_count = 0; // Mismatches seen
  int           n_compared = 0; // Comparisons made
  logic [10:0]  pa [8];         // Pushed return addresses
  logic [10:0]  p;              // Address before an operation

  // Half period of 12.5 ns
  always #12.5 clk_in = ~clk_in;

  cvrt_rom_model rom (.addr_in(addr), .data_out(rdata));

  cvrt_core uut (
    .clk_in(clk_in), .reset_n_in(rst_n), .rst_cause_in(cause),
    .op_valid_in(opv), .op_in(op), .op_value_in(opval),
    .idx_lo_inc_in(inc), .idx_lo_wr_in(lowr), .idx_mid_wr_in(midwr),
    .idx_data_in(idat), .value_wr_in(vwr), .flags_wr_in(fwr),
    .wdata_in(wdat), .rom_data_in(rdata), .rom_addr_out(addr),
    .working_value_out(val), .status_flag_byte_out(flg),
    .table_high_out(hi), .idx_lo_out(lo), .idx_mid_out(mid),
    .busy_out(busy));

  // Comparisons, one per kind of result
  task automatic chk_addr(input logic [10:0] g, input logic [10:0] e);
    n_compared++;
    if (g !== e) begin
      $display("Error at %0t: got %h expected %h", $time, g, e);
      fail_count++;
    end
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      $display("Error at %0t: got %h expected %h", $time, g, e);
      fail_count++;
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      $display("Error at %0t: got %h expected %h", $time, g, e);
      fail_count++;
    end
  endtask

  // Inputs move only at falling edges
  task automatic cyc();
    @(negedge clk_in);
  endtask
  // Valid stays up so operations can run back to back
  task automatic send(input cvrt_op_type o, input logic [7:0] v);
    opv = 1'b1;
    op = o;
    opval = v;
    cyc();
  endtask
  task automatic load(input logic [7:0] v, input logic [7:0] f);
    vwr = 1'b1;
    wdat = v;
    cyc();
    vwr = 1'b0;
    fwr = 1'b1;
    wdat = f;
    cyc();
    fwr = 1'b0;
  endtask

  // Reset with a given cause, then check defaults and flags
  task automatic do_reset(input cvrt_rst_type c, input int n);
    logic [7:0] e;
    e = (c == CVRT_RST_POWER) ? 8'h10 : (c == CVRT_RST_EXT) ? 8'h30 : 8'h00;
    rst_n = 1'b0;
    cause = c;
    opv = 1'b0;
    repeat (n) cyc();
    chk_bit(busy, 1'b1);
    chk_addr(addr, 11'h000);
    rst_n = 1'b1;
    cyc();
    chk_addr(addr, CVRT_RESET_VEC);
    chk_byte(flg, e);
    chk_byte(val, 8'h00);
  endtask

  task automatic t_reset();
    do_reset(CVRT_RST_POWER, 2);
    do_reset(CVRT_RST_WDOG, 2);
    do_reset(CVRT_RST_EXT, 2);
    repeat (3) cyc();
    chk_addr(addr, 11'h003);
    $display("test reset done");
  endtask

  // Eight nested interrupts, then eight returns
  task automatic t_stack();
    for (int i = 0; i < 8; i++) begin
      opv = 1'b0;
      repeat (i + 1) cyc();
      pa[i] = addr;
      send(CVRT_OP_IRQ, 8'h00);
      chk_addr(addr, CVRT_IRQ_VEC);
    end
    for (int i = 7; i >= 0; i--) begin
      send(CVRT_OP_RETURN_FROM_INTERRUPT, 8'h00);
      chk_addr(addr, pa[i]);
    end
    opv = 1'b0;
    $display("test stack done");
  endtask

  // Second save overwrites the first; flag bits 4 and 5 survive
  task automatic t_shadow();
    send(CVRT_OP_RESTORE, 8'h00);
    opv = 1'b0;
    chk_byte(flg, 8'h30);
    load(8'h5A, 8'hC3);
    send(CVRT_OP_SAVE, 8'h00);
    opv = 1'b0;
    load(8'h77, 8'h0C);
    send(CVRT_OP_SAVE, 8'h00);
    opv = 1'b0;
    load(8'h11, 8'h81);
    chk_byte(flg, 8'hB1);
    send(CVRT_OP_RESTORE, 8'h00);
    opv = 1'b0;
    chk_byte(val, 8'h77);
    chk_byte(flg, 8'h3C);
    $display("test shadow done");
  endtask

  // Table read with spare index bits, a refused request inside it
  task automatic t_table();
    midwr = 1'b1;
    idat = 8'hFB;
    cyc();
    midwr = 1'b0;
    lowr = 1'b1;
    idat = 8'h34;
    cyc();
    lowr = 1'b0;
    p = addr;
    send(CVRT_OP_TABLE, 8'h00);
    op = CVRT_OP_IRQ;
    chk_addr(addr, 11'h334);
    chk_bit(busy, 1'b1);
    cyc();
    opv = 1'b0;
    chk_addr(addr, p + 11'h001);
    chk_byte(val, 8'h34);
    chk_byte(hi, 8'hAB);
    chk_bit(busy, 1'b0);
    lowr = 1'b1;
    idat = 8'hFF;
    cyc();
    lowr = 1'b0;
    inc = 1'b1;
    cyc();
    inc = 1'b0;
    chk_byte(lo, 8'h00);
    chk_byte(mid, 8'hFB);
    $display("test table done");
  endtask

  // Computed jumps: plain add, carry into high byte, borrow kept
  task automatic t_jump();
    send(CVRT_OP_IRQ, 8'h00);
    send(CVRT_OP_PCL_ADD, 8'h03);
    chk_addr(addr, 11'h00B);
    send(CVRT_OP_PCL_ADD, 8'hF5);
    chk_addr(addr, 11'h100);
    send(CVRT_OP_PCL_SUB, 8'h01);
    chk_addr(addr, 11'h1FF);
    send(CVRT_OP_STEP, 8'h00);
    chk_addr(addr, 11'h200);
    opv = 1'b0;
    $display("test jump done");
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence, opening reset held twelve cycles
  initial begin
    do_reset(CVRT_RST_POWER, 12);
    t_reset();
    t_stack();
    t_shadow();
    t_table();
    t_jump();
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
